// ### logic/reset_timeout_irq_watchdog.sv
// Reset time-out sequencer, interrupt controller and watchdog
// Functional notes
// R01: After power-on, run power-up delay, then oscillator start-up count.
// R02: Crystal modes: 72 ms plus 1024 periods, or 1024 only.
// R03: RC mode: 72 ms when enabled, otherwise no delay at all.
// R04: Time-outs run regardless of reset pin; release starts at once.
// R05: Reset cause coded in time-out and power-down flags.
// R06: Power-on sets both time-out and power-down flags.
// R07: Four sources: pin edge, timer, port change, EEPROM write done.
// R08: Global enable bit 7 gates all interrupts, cleared by reset.
// R09: Return-from-interrupt sets the global enable again.
// R10: Taking an interrupt clears enable, pushes PC, loads vector.
// R11: Pin and port-change latency three to four instruction cycles.
// R12: Flags set on events whatever the enables.
// R13: Software clears serviced flags before re-enabling interrupts.
// R14: Pin edge chosen by option bit 6; sets flag bit 1.
// R15: Pin enable bit 4 masks; wakes only if set before sleep.
// R16: Timer rollover sets flag bit 2, masked by enable bit 5.
// R17: Port change on upper pins sets bit 0, enable bit 3.
// R18: Only return PC is saved on interrupt entry.
// R19: Watchdog on own oscillator; resets in run, wakes in sleep.
// R20: Watchdog enable configuration bit zero disables it for good.
// R21: Watchdog 18 ms base, prescaler up to 1:128 when assigned.
// R22: Clear-watchdog and sleep reset watchdog count and prescaler.
// R23: Power-down flag set at power-up, cleared by sleep.
// R24: Enabled interrupt wakes sleep regardless of global enable. Here the timer flag never wakes.
// R25: Pin and port events are synchronised before setting flags.
//
// Our own choice: the APB register port.
`include "rtiw_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module reset_timeout_irq_watchdog #(
  parameter int POWERUP_TIMER_CYCLES = `POWERUP_TIMER_MS * 1000000 / `CLK_PERIOD_NS,
  parameter int WDT_TICK_NS = `WDT_TICK_NS_DEF
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic por_pulse,
  input wire logic [7:0] cfg_word,
  input wire logic external_reset_pin_n,
  input wire logic ext_irq_pin,
  input wire logic [3:0] port_b_pins,
  input wire logic wdt_osc,
  input wire logic timer_rollover,
  input wire logic eeprom_write_done,
  input wire logic instr_cycle,
  input wire logic sleep_instr,
  input wire logic clear_watchdog_instr,
  input wire logic return_from_irq,
  input wire logic [`PC_W-1:0] cpu_pc,
  output logic cpu_reset_n,
  output logic in_sleep,
  output logic wake_pulse,
  output logic vector_load,
  output logic [`PC_W-1:0] vector_pc,
  output logic stack_push,
  output logic [`PC_W-1:0] push_pc
);

  localparam int OST_CYCLES = `OST_TOSC;
  localparam int WDT_TICKS = `WDT_MS * 1000000 / WDT_TICK_NS;

  rtiw_pkg::seq_state_t state_r;
  logic [31:0] tmo_cnt_r;
  logic from_sleep_r;
  logic [7:0] cfg_r;
  logic [7:0] option_r;
  logic [7:0] intctl_r;
  logic ee_flag_r;
  logic to_flag_r;
  logic pd_flag_r;
  logic [3:0] en_at_sleep_r;
  logic [`SYNC_N-1:0] sy1_r, sy2_r, sy3_r, pin_r;
  logic irq_prev_r;
  logic wdt_prev_r;
  logic [3:0] pb_seen_r;
  logic [6:0] pre_cnt_r;
  logic [15:0] wdt_cnt_r;
  logic wdt_to_r;
  logic [1:0] irq_stage_r;

  // Decode of one register index
  function automatic logic hit(input logic [`ADDR_W-1:0] a,
                               input logic [`IDX_W-1:0] idx);
    hit = (a[`ADDR_W-1:2] == idx) && (a[1:0] == 2'b00);
  endfunction

  function automatic logic crystal(input logic [7:0] c);
    crystal = {c[`CFG_OSC_HI], c[`CFG_OSC_LO]} != `OSC_RC;
  endfunction

  // Comb events
  logic apb_done, wr_en;
  logic rst_pin, pin_edge, pb_change, wdt_tick;
  logic [3:0] flags, enables;
  logic pend_any, wake_irq, held, running;
  logic take_irq, sleep_go, wdt_run_rst, wdt_wake;
  logic ext_run, ext_sleep;

  assign apb_done = psel & penable & pready;
  assign wr_en = apb_done & pwrite;
  assign rst_pin = pin_r[`SY_RST];
  assign wdt_tick = pin_r[`SY_WDT] & ~wdt_prev_r;
  assign pin_edge = option_r[`OP_EDGE] ?
                    (pin_r[`SY_IRQ] & ~irq_prev_r) :
                    (~pin_r[`SY_IRQ] & irq_prev_r); // R14
  // Change counted at an instruction boundary, so a glitch shorter
  // than one instruction cycle may be missed
  assign pb_change = instr_cycle &&
         (pin_r[`SY_PB_HI:`SY_PB_LO] != pb_seen_r); // R17
  assign flags = {ee_flag_r, intctl_r[`IC_TMR_FLAG],
                  intctl_r[`IC_PIN_FLAG], intctl_r[`IC_PB_FLAG]};
  assign enables = {intctl_r[`IC_EE_EN], intctl_r[`IC_TMR_EN],
                    intctl_r[`IC_PIN_EN], intctl_r[`IC_PB_EN]};
  assign pend_any = |(flags & enables);
  // Timer has no clock in sleep, so it never wakes the device
  assign wake_irq = |(flags & en_at_sleep_r & 4'b1011); // R15 R24
  assign running = state_r == rtiw_pkg::SEQ_RUN;
  assign held = (state_r == rtiw_pkg::SEQ_POR) ||
                (state_r == rtiw_pkg::SEQ_POWERUP_TIMER) ||
                (state_r == rtiw_pkg::SEQ_HOLD) ||
                (state_r == rtiw_pkg::SEQ_OST && !from_sleep_r);
  // Pending enabled source turns sleep into a no-op
  assign sleep_go = running & sleep_instr & ~pend_any;
  assign take_irq = running & instr_cycle & intctl_r[`IC_GIE] &
                    pend_any & (irq_stage_r == 2'd1);
  assign wdt_run_rst = running & wdt_to_r & rst_pin; // R19
  assign wdt_wake = (state_r == rtiw_pkg::SEQ_SLEEP) & wdt_to_r & rst_pin;
  assign ext_run = running & ~rst_pin;
  assign ext_sleep = (state_r == rtiw_pkg::SEQ_SLEEP) & ~rst_pin;

  // Three-stage pin synchronisers; a level is taken once the second and third stages agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sy1_r <= '0;
      sy2_r <= '0;
      sy3_r <= '0;
      pin_r <= '0;
    end else if (clk_en) begin
      sy1_r <= {wdt_osc, external_reset_pin_n, ext_irq_pin, port_b_pins};
      sy2_r <= sy1_r;
      sy3_r <= sy2_r;
      pin_r <= (sy2_r & sy3_r) | (pin_r & (sy2_r | sy3_r)); // R25
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_prev_r <= 1'b0;
      wdt_prev_r <= 1'b0;
      pb_seen_r <= '0;
    end else if (clk_en) begin
      irq_prev_r <= pin_r[`SY_IRQ];
      wdt_prev_r <= pin_r[`SY_WDT];
      if (instr_cycle) begin
        pb_seen_r <= pin_r[`SY_PB_HI:`SY_PB_LO];
      end
    end
  end

  // Reset and wake-up sequencer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= rtiw_pkg::SEQ_POR;
      tmo_cnt_r <= '0;
      from_sleep_r <= 1'b0;
      cfg_r <= '0;
    end else if (clk_en) begin
      if (por_pulse) begin
        state_r <= rtiw_pkg::SEQ_POR;
        tmo_cnt_r <= '0;
      end else begin
        case (state_r)
          rtiw_pkg::SEQ_POR: begin
            cfg_r <= cfg_word;
            from_sleep_r <= 1'b0;
            tmo_cnt_r <= '0;
            if (cfg_word[`CFG_POWERUP_TIMER_EN]) begin
              state_r <= rtiw_pkg::SEQ_POWERUP_TIMER; // R01
            end else if (crystal(cfg_word)) begin
              state_r <= rtiw_pkg::SEQ_OST; // R02
            end else begin
              state_r <= rtiw_pkg::SEQ_HOLD; // R03
            end
          end
          rtiw_pkg::SEQ_POWERUP_TIMER: begin
            // Counts whatever the reset pin does
            if (tmo_cnt_r == 32'(POWERUP_TIMER_CYCLES - 1)) begin // R04
              tmo_cnt_r <= '0;
              state_r <= crystal(cfg_r) ? rtiw_pkg::SEQ_OST
                                        : rtiw_pkg::SEQ_HOLD; // R01 R03
            end else begin
              tmo_cnt_r <= tmo_cnt_r + 32'd1;
            end
          end
          rtiw_pkg::SEQ_OST: begin
            if (from_sleep_r && !rst_pin) begin
              state_r <= rtiw_pkg::SEQ_HOLD;
            end else if (tmo_cnt_r == 32'(OST_CYCLES - 1)) begin // R02
              tmo_cnt_r <= '0;
              state_r <= from_sleep_r ? rtiw_pkg::SEQ_RUN
                                      : rtiw_pkg::SEQ_HOLD;
            end else begin
              tmo_cnt_r <= tmo_cnt_r + 32'd1;
            end
          end
          rtiw_pkg::SEQ_HOLD: begin
            from_sleep_r <= 1'b0;
            if (rst_pin) begin
              state_r <= rtiw_pkg::SEQ_RUN; // R04
            end
          end
          rtiw_pkg::SEQ_RUN: begin
            if (ext_run || wdt_run_rst) begin
              state_r <= rtiw_pkg::SEQ_HOLD; // R19
            end else if (sleep_go) begin
              state_r <= rtiw_pkg::SEQ_SLEEP;
            end
          end
          rtiw_pkg::SEQ_SLEEP: begin
            tmo_cnt_r <= '0;
            if (ext_sleep) begin
              state_r <= rtiw_pkg::SEQ_HOLD;
            end else if (wdt_wake || wake_irq) begin // R19 R24
              from_sleep_r <= 1'b1;
              state_r <= crystal(cfg_r) ? rtiw_pkg::SEQ_OST
                                        : rtiw_pkg::SEQ_RUN; // R02 R03
            end
          end
          default: state_r <= rtiw_pkg::SEQ_POR;
        endcase
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cpu_reset_n <= 1'b0;
      in_sleep <= 1'b0;
      wake_pulse <= 1'b0;
    end else if (clk_en) begin
      cpu_reset_n <= !held && !por_pulse && !ext_run && !wdt_run_rst;
      in_sleep <= state_r == rtiw_pkg::SEQ_SLEEP;
      wake_pulse <= (state_r == rtiw_pkg::SEQ_SLEEP) &&
                    !ext_sleep && (wdt_wake || wake_irq);
    end
  end

  // Reset-cause flags
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      to_flag_r <= 1'b1;
      pd_flag_r <= 1'b1;
    end else if (clk_en) begin
      if (state_r == rtiw_pkg::SEQ_POR) begin
        to_flag_r <= 1'b1; // R06
        pd_flag_r <= 1'b1; // R23
      end else if (ext_run) begin
        to_flag_r <= 1'b1; // R05
        pd_flag_r <= 1'b1;
      end else if (ext_sleep) begin
        to_flag_r <= 1'b1; // R05
        pd_flag_r <= 1'b0;
      end else if (wdt_run_rst) begin
        to_flag_r <= 1'b0; // R05
        pd_flag_r <= 1'b1;
      end else if (wdt_wake) begin
        to_flag_r <= 1'b0; // R05
        pd_flag_r <= 1'b0;
      end else if (sleep_go) begin
        to_flag_r <= 1'b1;
        pd_flag_r <= 1'b0; // R23
      end else if (running && clear_watchdog_instr) begin
        to_flag_r <= 1'b1;
        pd_flag_r <= 1'b1;
      end
    end
  end

  // Watchdog on its own oscillator ticks
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_cnt_r <= '0;
      wdt_cnt_r <= '0;
      wdt_to_r <= 1'b0;
    end else if (clk_en) begin
      wdt_to_r <= 1'b0;
      if (held || !cfg_r[`CFG_WDT_EN] ||
          sleep_go || (running && clear_watchdog_instr)) begin
        pre_cnt_r <= '0; // R20 R22
        wdt_cnt_r <= '0;
      end else if (wdt_tick) begin // R19
        if (option_r[`OP_PSA] &&
            pre_cnt_r != 7'((8'd1 << option_r[`OP_PS_HI:`OP_PS_LO]) - 8'd1))
        begin
          pre_cnt_r <= pre_cnt_r + 7'd1; // R21
        end else begin
          pre_cnt_r <= '0;
          if (wdt_cnt_r == 16'(WDT_TICKS - 1)) begin // R21
            wdt_cnt_r <= '0;
            wdt_to_r <= 1'b1;
          end else begin
            wdt_cnt_r <= wdt_cnt_r + 16'd1;
          end
        end
      end
    end
  end

  // Interrupt control; hardware set wins over a software clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      intctl_r <= `INTCTL_RST;
      ee_flag_r <= 1'b0;
      en_at_sleep_r <= '0;
    end else if (clk_en) begin
      if (wr_en && hit(paddr, `IDX_INTCTL)) begin
        intctl_r <= pwdata[7:0];
      end
      if (wr_en && hit(paddr, `IDX_STATUS)) begin
        ee_flag_r <= pwdata[`ST_EE_FLAG];
      end
      if (return_from_irq && running) begin
        intctl_r[`IC_GIE] <= 1'b1; // R09
      end
      if (take_irq) begin
        intctl_r[`IC_GIE] <= 1'b0; // R10
      end
      if (held) begin
        intctl_r[`IC_GIE] <= 1'b0; // R08
      end
      if (pin_edge) begin
        intctl_r[`IC_PIN_FLAG] <= 1'b1; // R12 R14
      end
      if (timer_rollover) begin
        intctl_r[`IC_TMR_FLAG] <= 1'b1; // R12 R16
      end
      if (pb_change) begin
        intctl_r[`IC_PB_FLAG] <= 1'b1; // R12 R17
      end
      if (eeprom_write_done) begin
        ee_flag_r <= 1'b1; // R07
      end
      if (sleep_go) begin
        en_at_sleep_r <= enables; // R15
      end
    end
  end

  // Vectoring; only the return PC leaves with the push
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stage_r <= '0;
      vector_load <= 1'b0;
      stack_push <= 1'b0;
      vector_pc <= '0;
      push_pc <= '0;
    end else if (clk_en) begin
      vector_load <= take_irq;
      stack_push <= take_irq;
      if (!running || !intctl_r[`IC_GIE] || !pend_any) begin
        irq_stage_r <= '0;
      end else if (instr_cycle) begin
        irq_stage_r <= take_irq ? 2'd0 : 2'd1; // R11
      end
      if (take_irq) begin
        vector_pc <= `VECTOR_ADDR; // R10
        push_pc <= cpu_pc; // R18
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      option_r <= `OPTION_RST;
    end else if (clk_en) begin
      if (held) begin
        option_r <= `OPTION_RST;
      end else if (wr_en && hit(paddr, `IDX_OPTION)) begin
        option_r <= pwdata[7:0];
      end
    end
  end

  // APB slave, one wait state on every access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= '0;
    end else if (clk_en) begin
      pready <= psel & penable & ~pready;
      pslverr <= 1'b0;
      prdata <= '0;
      if (psel && penable && !pready) begin
        if (hit(paddr, `IDX_OPTION)) begin
          prdata <= {24'h000000, option_r};
        end else if (hit(paddr, `IDX_INTCTL)) begin
          prdata <= {24'h000000, intctl_r};
        end else if (hit(paddr, `IDX_CONFIG)) begin
          prdata <= {24'h000000, cfg_r};
        end else if (hit(paddr, `IDX_STATUS)) begin
          prdata <= {24'h000000, in_sleep, 1'b0, ee_flag_r,
                     to_flag_r, pd_flag_r, 3'b000}; // R05
        end else begin
          pslverr <= 1'b1;
        end
        if (pwrite) begin
          prdata <= '0;
        end
      end
    end
  end

endmodule

`default_nettype wire

// ### pkg/rtiw_defs.svh
// Offsets, field positions, reset values and timing figures of the supervisor
`ifndef RTIW_DEFS_SVH
`define RTIW_DEFS_SVH

`define CLK_PERIOD_NS 50
`define POWERUP_TIMER_MS 72
`define OST_TOSC 1024
`define WDT_MS 18
`define WDT_TICK_NS_DEF 70312

`define ADDR_W 16
`define IDX_W 14
`define IDX_STATUS 14'h0003
`define IDX_INTCTL 14'h000b
`define IDX_OPTION 14'h0081
`define IDX_CONFIG 14'h2007

`define OPTION_RST 8'hff
`define INTCTL_RST 8'h00
`define VECTOR_ADDR 13'h0004
`define PC_W 13

`define IC_GIE 7
`define IC_EE_EN 6
`define IC_TMR_EN 5
`define IC_PIN_EN 4
`define IC_PB_EN 3
`define IC_TMR_FLAG 2
`define IC_PIN_FLAG 1
`define IC_PB_FLAG 0

`define OP_EDGE 6
`define OP_PSA 3
`define OP_PS_HI 2
`define OP_PS_LO 0

`define ST_SLEEP_BIT 7
`define ST_EE_FLAG 5
`define ST_TO 4
`define ST_PD 3

`define CFG_POWERUP_TIMER_EN 3
`define CFG_WDT_EN 2
`define CFG_OSC_HI 1
`define CFG_OSC_LO 0
`define OSC_RC 2'b11

`define SYNC_N 7
`define SY_PB_LO 0
`define SY_PB_HI 3
`define SY_IRQ 4
`define SY_RST 5
`define SY_WDT 6

`endif

// ### pkg/rtiw_pkg.sv
// Types shared by the supervisor design
package rtiw_pkg;
  typedef enum logic [2:0] {
    SEQ_POR,
    SEQ_POWERUP_TIMER,
    SEQ_OST,
    SEQ_HOLD,
    SEQ_RUN,
    SEQ_SLEEP
  } seq_state_t;
endpackage

// ### verification/rtiw_asserts.sv
// Concurrent checks on the supervisor ports
`timescale 1ns/1ps
`default_nettype none
`include "rtiw_defs.svh"
module rtiw_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic por_pulse,
  input wire logic external_reset_pin_n,
  input wire logic sleep_instr,
  input wire logic clear_watchdog_instr,
  input wire logic [`PC_W-1:0] cpu_pc,
  input wire logic cpu_reset_n,
  input wire logic in_sleep,
  input wire logic wake_pulse,
  input wire logic vector_load,
  input wire logic [`PC_W-1:0] vector_pc,
  input wire logic stack_push,
  input wire logic [`PC_W-1:0] push_pc
);
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  AST_APB_ANSWER: assert property (
    psel && penable && !pready && clk_en |=> pready)
    else $error("apb access not answered");
  AST_ERR_WITH_READY: assert property (pslverr |-> pready)
    else $error("error flag outside answer");
  AST_POR_HOLDS: assert property (por_pulse |=> !cpu_reset_n)
    else $error("core not held after power-on pulse");
  // Seven samples: a pin low in sleep takes one extra step through hold
  AST_PIN_HOLDS: assert property (
    !external_reset_pin_n [*7] |-> !cpu_reset_n)
    else $error("core runs while reset pin low");
  AST_RESET_NO_VECTOR: assert property (
    !cpu_reset_n |-> !vector_load && !stack_push)
    else $error("vector taken while core held");
  AST_VECTOR_PUSH: assert property (
    vector_load |-> stack_push && vector_pc == `VECTOR_ADDR)
    else $error("vector entry incomplete");
  AST_PUSH_PC: assert property (
    stack_push |-> push_pc == $past(cpu_pc))
    else $error("pushed pc differs from return pc");
  AST_NO_RETAKE: assert property (vector_load |=> !vector_load [*2])
    else $error("vector retaken with enable cleared");
  AST_SLEEP_CAUSE: assert property (
    $rose(in_sleep) |-> $past(sleep_instr) || $past(sleep_instr, 2))
    else $error("sleep without sleep instruction");
  AST_WAKE_FROM_SLEEP: assert property (wake_pulse |-> $past(in_sleep))
    else $error("wake outside sleep");
  AST_CLEAR_WATCHDOG_INSTR: assert property (
    clear_watchdog_instr && cpu_reset_n && external_reset_pin_n &&
    !por_pulse |=> cpu_reset_n)
    else $error("reset right after watchdog clear");
  cover property (vector_load);
  cover property (wake_pulse);
  cover property ($fell(cpu_reset_n) && external_reset_pin_n);
endmodule
bind reset_timeout_irq_watchdog rtiw_chk u_chk (.pclk(pclk), .presetn(presetn),
  .clk_en(clk_en), .psel(psel), .penable(penable), .pready(pready),
  .pslverr(pslverr), .por_pulse(por_pulse),
  .external_reset_pin_n(external_reset_pin_n), .sleep_instr(sleep_instr),
  .clear_watchdog_instr(clear_watchdog_instr), .cpu_pc(cpu_pc),
  .cpu_reset_n(cpu_reset_n), .in_sleep(in_sleep), .wake_pulse(wake_pulse),
  .vector_load(vector_load), .vector_pc(vector_pc), .stack_push(stack_push),
  .push_pc(push_pc));
`default_nettype wire

// ### verification/rtiw_pins.sv
// Model of the reset pin, interrupt pin, port pins and watchdog oscillator
`timescale 1ns/1ps
`default_nettype none
module rtiw_pins #(
  parameter int OSC_HALF_NS = 185
) (
  input wire logic pclk,
  output logic external_reset_pin_n,
  output logic ext_irq_pin,
  output logic [3:0] port_b_pins,
  output logic wdt_osc
);
  initial begin
    external_reset_pin_n = 1'b0;
    ext_irq_pin = 1'b0;
    port_b_pins = 4'h0;
    wdt_osc = 1'b0;
  end
  // Free running, unrelated to pclk, not stopped by sleep
  always #(OSC_HALF_NS) wdt_osc = ~wdt_osc;
  task automatic drive(input logic r, input logic i, input logic [3:0] p);
    @(posedge pclk);
    external_reset_pin_n <= r;
    ext_irq_pin <= i;
    port_b_pins <= p;
  endtask
endmodule
`default_nettype wire

// ### verification/reset_timeout_irq_watchdog_bench.sv
// Bench for the reset, interrupt and watchdog supervisor
`timescale 1ns/1ps
`default_nettype none
`include "rtiw_defs.svh"
module reset_timeout_irq_watchdog_bench;
  localparam int PW = 20;
  localparam int OSC_STARTUP_TIMER = `OST_TOSC;
  localparam int IC = 4;
  localparam logic [12:0] RET_PC = 13'h0123;
  localparam logic [15:0] ST = {`IDX_STATUS, 2'b00};
  localparam logic [15:0] ICA = {`IDX_INTCTL, 2'b00};
  localparam logic [15:0] OPT = {`IDX_OPTION, 2'b00};
  localparam logic [15:0] CFG = {`IDX_CONFIG, 2'b00};
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [15:0] paddr = 16'h0000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic por_pulse = 1'b0;
  logic [7:0] cfg = 8'h08;
  logic instr_cycle = 1'b0;
  logic [4:0] ev = 5'h00;
  logic [31:0] prdata, q;
  logic pready, pslverr, rst_n, in_sleep, wake, vload, spush, rpin, irq, osc;
  logic e;
  logic [12:0] vpc, ppc;
  logic [3:0] pb;
  logic [7:0] pcfg [4] = '{8'h08, 8'h00, 8'h0b, 8'h03};
  int pdly [4] = '{PW + OSC_STARTUP_TIMER, OSC_STARTUP_TIMER, PW, 0};
  logic [7:0] fm [3] = '{8'h02, 8'h04, 8'h01};
  int bad_count = 0;
  int total_checks = 0;
  int vec_count = 0;
  int rst_falls = 0;
  int cyc = 0;
  int n, m;
  always #25 pclk = ~pclk;
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    instr_cycle <= (cyc % IC == IC - 1);
    if (vload === 1'b1) begin
      vec_count <= vec_count + 1;
    end
  end
  always @(negedge rst_n) rst_falls++;
  rtiw_pins u_pins (.pclk(pclk), .external_reset_pin_n(rpin),
    .ext_irq_pin(irq), .port_b_pins(pb), .wdt_osc(osc));
  reset_timeout_irq_watchdog #(.POWERUP_TIMER_CYCLES(PW), .WDT_TICK_NS(4500000)) u_dut (
    .pclk(pclk), .presetn(presetn), .clk_en(1'b1), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .por_pulse(por_pulse), .cfg_word(cfg), .external_reset_pin_n(rpin),
    .ext_irq_pin(irq), .port_b_pins(pb), .wdt_osc(osc),
    .timer_rollover(ev[0]), .eeprom_write_done(ev[1]),
    .instr_cycle(instr_cycle), .sleep_instr(ev[2]),
    .clear_watchdog_instr(ev[3]), .return_from_irq(ev[4]), .cpu_pc(RET_PC),
    .cpu_reset_n(rst_n), .in_sleep(in_sleep), .wake_pulse(wake),
    .vector_load(vload), .vector_pc(vpc), .stack_push(spush),
    .push_pc(ppc));
  task end_sim;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    total_checks++;
    if (got !== ex) begin
      bad_count++;
      $display("BAD %s exp %h got %h", nm, ex, got);
    end
  endtask
  task rng(input string nm, input int lo, input int hi);
    total_checks++;
    if (n < lo || n > hi) begin
      bad_count++;
      $display("BAD %s exp %0d..%0d got %0d", nm, lo, hi, n);
    end
  endtask
  // Request held until pready is sampled high
  task apb(input logic w, input logic [15:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k >= 20) begin
      bad_count++;
      end_sim;
    end
  endtask
  task rd(input logic [15:0] a, input logic [7:0] mk, input logic [7:0] ex,
          input string nm);
    apb(1'b0, a, 32'h0);
    chk(nm, {24'h0, ex}, q & {24'h0, mk});
  endtask
  task pulse(input int b);
    @(posedge pclk);
    ev[b] <= 1'b1;
    @(posedge pclk);
    ev <= 5'h00;
  endtask
  function automatic logic sg(input int k);
    case (k)
      0: return rst_n;
      1: return vload;
      2: return in_sleep;
      default: return wake;
    endcase
  endfunction
  task wt(input int k, input logic v, input int lim);
    n = 0;
    while (sg(k) !== v && n < lim) begin
      @(posedge pclk);
      n++;
    end
    if (sg(k) !== v) begin
      bad_count++;
      $display("BAD wait %0d exp %b got %b", k, v, sg(k));
      end_sim;
    end
  endtask
  task por(input logic [7:0] c, input int dly);
    @(posedge pclk);
    cfg <= c;
    por_pulse <= 1'b1;
    @(posedge pclk);
    por_pulse <= 1'b0;
    @(posedge pclk);
    wt(0, 1'b1, dly + 60);
    rng("power-on delay", dly, dly + 12);
  endtask
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    repeat (PW + OSC_STARTUP_TIMER + 200) @(posedge pclk);
    chk("held by pin", 32'h0, 32'(rst_n));
    u_pins.drive(1'b1, 1'b0, 4'h0);
    repeat (8) @(posedge pclk);
    chk("prompt start", 32'h1, 32'(rst_n));
    rd(ST, 8'h18, 8'h18, "status after power-on");
    rd(OPT, 8'hff, 8'hff, "option reset");
    rd(ICA, 8'hff, 8'h00, "intctl reset");
    apb(1'b1, CFG, 32'h0);
    rd(CFG, 8'hff, 8'h08, "config read only");
    apb(1'b0, 16'h0100, 32'h0);
    chk("unmapped err", 32'h1, 32'(e));
    chk("unmapped data", 32'h0, q);
    for (int i = 0; i < 4; i++) begin
      por(pcfg[i], pdly[i]);
    end
    for (int i = 0; i < 4; i++) begin
      case (i)
        0: u_pins.drive(1'b1, 1'b1, 4'h0);
        1: pulse(0);
        2: u_pins.drive(1'b1, 1'b1, 4'ha);
        default: pulse(1);
      endcase
      // Pin levels held two instruction cycles
      repeat (2 * IC) @(posedge pclk);
      if (i == 3) begin
        rd(ST, 8'h20, 8'h20, "eeprom flag");
      end else begin
        rd(ICA, fm[i], fm[i], "masked flag");
      end
    end
    chk("no vector when masked", 32'h0, vec_count);
    apb(1'b1, ICA, 32'h0);
    apb(1'b1, ST, 32'h0);
    apb(1'b1, OPT, 32'hbf);
    apb(1'b1, ICA, 32'h90);
    u_pins.drive(1'b1, 1'b0, 4'ha);
    wt(1, 1'b1, 40);
    rng("irq latency", IC, 4 * IC + 2);
    chk("vector", {19'h0, `VECTOR_ADDR}, {19'h0, vpc});
    chk("pushed pc", {19'h0, RET_PC}, {19'h0, ppc});
    rd(ICA, 8'hff, 8'h12, "enable cleared");
    apb(1'b1, ICA, 32'h10);
    pulse(4);
    rd(ICA, 8'hff, 8'h90, "enable restored");
    repeat (30) @(posedge pclk);
    chk("single entry", 32'h1, vec_count);
    por(8'h07, 0);
    apb(1'b1, OPT, 32'h08);
    pulse(3);
    wt(0, 1'b0, 300);
    wt(0, 1'b1, 20);
    rd(ST, 8'h18, 8'h08, "watchdog reset cause");
    apb(1'b1, OPT, 32'h08);
    m = rst_falls;
    repeat (12) begin
      pulse(3);
      repeat (8) @(posedge pclk);
    end
    chk("cleared in time", m, rst_falls);
    pulse(3);
    pulse(2);
    wt(2, 1'b1, 10);
    rd(ST, 8'h98, 8'h90, "sleep entry");
    wt(3, 1'b1, 300);
    rd(ST, 8'h18, 8'h00, "watchdog wake cause");
    apb(1'b1, OPT, 32'h0f);
    pulse(3);
    u_pins.drive(1'b1, 1'b1, 4'ha);
    repeat (8) @(posedge pclk);
    apb(1'b1, ICA, 32'h10);
    pulse(2);
    wt(2, 1'b1, 10);
    m = vec_count;
    u_pins.drive(1'b1, 1'b0, 4'ha);
    wt(3, 1'b1, 40);
    rd(ST, 8'h18, 8'h10, "irq wake cause");
    repeat (20) @(posedge pclk);
    chk("in line after wake", m, vec_count);
    end_sim;
  end
  initial begin
    repeat (60000) @(posedge pclk);
    bad_count++;
    end_sim;
  end
endmodule
`default_nettype wire
